/* core/gdc_map.vh */
`ifndef GDC_MAP_VH
`define GDC_MAP_VH

// Register addresses (word registers, 16 bits each).
`define GDC_ADDR_DIRECT      6'h23
`define GDC_ADDR_FORCE       6'h24
`define GDC_ADDR_SOURCE      6'h25
`define GDC_ADDR_SINK        6'h26
`define GDC_ADDR_SENSE       6'h29

// Reset values.
`define GDC_RST_DIRECT       16'h0000
`define GDC_RST_FORCE        16'h0007
`define GDC_RST_SOURCE       16'h0000
`define GDC_RST_SINK         16'h0000
`define GDC_RST_SENSE        16'h0000

// Writable bit masks; everything else is reserved.
`define GDC_MASK_DIRECT      16'h0003
`define GDC_MASK_FORCE       16'h0007
`define GDC_MASK_SOURCE      16'h3F3F
`define GDC_MASK_SINK        16'hFFFF
`define GDC_MASK_SENSE       16'h8F00

// Field positions.
`define GDC_BIT_CMD_LOW_B    1
`define GDC_BIT_CMD_LOW_C    0
`define GDC_BIT_FORCE_A      2
`define GDC_BIT_FORCE_B      1
`define GDC_BIT_FORCE_C      0
`define GDC_HS_LSB           8
`define GDC_LS_LSB           0
`define GDC_HS_RATIO_LSB     14
`define GDC_LS_RATIO_LSB     6
`define GDC_BIT_REF_DIV      15
`define GDC_GAIN_A_LSB       8

// Mode and thresholds.
`define GDC_PWM_MODE_REG     3'h5
`define GDC_SINK_HIGH_MIN    6'h24

`endif

/* core/gdc_config_regs.v */
`timescale 1ns/100ps
`include "gdc_map.vh"

// Behaviour
// RULE1 - In register mode with driver enabled, phase B low gate follows its command bit.
// RULE2 - In register mode with driver enabled, phase C low gate follows its command bit.
// RULE3 - Enabled driver with phase A force bit 0 pulls both A gates low.
// RULE4 - Enabled driver with phase B force bit 0 pulls both B gates low.
// RULE5 - Enabled driver with phase C force bit 0 pulls both C gates low.
// RULE6 - Clearing a force bit never changes the master driver enable.
// RULE7 - Force bit at 1, its reset value, leaves phase gates under normal control.
// RULE8 - High-side source code used only when source config select is 1.
// RULE9 - Low-side source code used only when source config select is 1.
// RULE10 - High-side ratio scales sink to source by 1, 0.75, 0.5 or 0.25.
// RULE11 - Ratios apply only for sink codes below 100100b with select 0.
// RULE12 - With source config select 1 both ratio fields are ignored.
// RULE13 - Low-side ratio uses same encoding, gated by its own sink code.
// RULE14 - High-side sink code is six bits at 13..8, reset zero.
// RULE15 - Low-side sink code is six bits at 5..0, reset zero.
// RULE16 - Sense reference divides by 2 when divide bit 0, by 8 when 1.
// RULE17 - Phase A gain codes 0..8 map to 5,10,12,16,20,23,25,30,40.
// RULE18 - Gain codes 9 to 15 give a gain of 40.
// RULE19 - Gain changes apply at once, even while switching runs.
// RULE20 - With select 0 and sink code 100100b or above, source equals sink code.
// RULE21 - Reserved bits read zero and ignore writes.
module gdc_config_regs (
    input  wire        clk_i,
    input  wire        srst_i,
    input  wire        wr_en_i,
    input  wire        rd_en_i,
    input  wire [5:0]  addr_i,
    input  wire [15:0] wdata_i,
    output reg  [15:0] rdata_o,
    output reg         rvalid_o,
    input  wire [2:0]  pwm_mode_i,
    input  wire        master_driver_enable_i,
    input  wire        source_config_select_i,
    input  wire [5:0]  normal_gate_i,
    output reg         high_gate_out_a_o,
    output reg         low_gate_out_a_o,
    output reg         high_gate_out_b_o,
    output reg         low_gate_out_b_o,
    output reg         high_gate_out_c_o,
    output reg         low_gate_out_c_o,
    output reg  [5:0]  hs_source_current_o,
    output reg  [5:0]  ls_source_current_o,
    output reg  [1:0]  hs_strength_multiplier_o,
    output reg  [1:0]  ls_strength_multiplier_o,
    output reg         hs_ratio_active_o,
    output reg         ls_ratio_active_o,
    output reg  [5:0]  hs_sink_current_o,
    output reg  [5:0]  ls_sink_current_o,
    output reg  [3:0]  sense_ref_divisor_o,
    output reg  [5:0]  amp_gain_phase_a_o
);

    // The mode, enable and select inputs come from the device's own control logic on
    // this clock, so they are used directly without synchronisers.

    reg  [15:0] direct_gate_command_reg;
    reg  [15:0] phase_force_low_enables_reg;
    reg  [15:0] source_current_codes_reg;
    reg  [15:0] sink_current_and_ratio_reg;
    reg  [15:0] sense_amp_control_reg;

    wire        cmd_low_gate_b  = direct_gate_command_reg[`GDC_BIT_CMD_LOW_B];
    wire        cmd_low_gate_c  = direct_gate_command_reg[`GDC_BIT_CMD_LOW_C];
    wire        phase_a_force_n = phase_force_low_enables_reg[`GDC_BIT_FORCE_A];
    wire        phase_b_force_n = phase_force_low_enables_reg[`GDC_BIT_FORCE_B];
    wire        phase_c_force_n = phase_force_low_enables_reg[`GDC_BIT_FORCE_C];
    wire [5:0]  hs_source_code  = source_current_codes_reg[`GDC_HS_LSB +: 6];
    wire [5:0]  ls_source_code  = source_current_codes_reg[`GDC_LS_LSB +: 6];
    wire [5:0]  hs_sink_code    = sink_current_and_ratio_reg[`GDC_HS_LSB +: 6];
    wire [5:0]  ls_sink_code    = sink_current_and_ratio_reg[`GDC_LS_LSB +: 6];
    wire [1:0]  hs_ratio        = sink_current_and_ratio_reg[`GDC_HS_RATIO_LSB +: 2];
    wire [1:0]  ls_ratio        = sink_current_and_ratio_reg[`GDC_LS_RATIO_LSB +: 2];
    wire        sense_ref_divide = sense_amp_control_reg[`GDC_BIT_REF_DIV];
    wire [3:0]  gain_code_a     = sense_amp_control_reg[`GDC_GAIN_A_LSB +: 4];

    wire        reg_mode = (pwm_mode_i == `GDC_PWM_MODE_REG) && master_driver_enable_i;

    // Register writes; reserved bits are masked off so they stay zero.
    always @(posedge clk_i) begin
        if (srst_i) begin
            direct_gate_command_reg     <= `GDC_RST_DIRECT;
            phase_force_low_enables_reg <= `GDC_RST_FORCE; // RULE7
            source_current_codes_reg    <= `GDC_RST_SOURCE;
            sink_current_and_ratio_reg  <= `GDC_RST_SINK; // RULE14 RULE15
            sense_amp_control_reg       <= `GDC_RST_SENSE;
        end else if (wr_en_i) begin
            case (addr_i)
                `GDC_ADDR_DIRECT: begin
                    direct_gate_command_reg <= wdata_i & `GDC_MASK_DIRECT; // RULE21
                end
                `GDC_ADDR_FORCE: begin
                    // Only the force bits live here; the master enable is an input
                    // and cannot be disturbed by this write.
                    phase_force_low_enables_reg <= wdata_i & `GDC_MASK_FORCE; // RULE6
                end
                `GDC_ADDR_SOURCE: begin
                    source_current_codes_reg <= wdata_i & `GDC_MASK_SOURCE; // RULE21
                end
                `GDC_ADDR_SINK: begin
                    sink_current_and_ratio_reg <= wdata_i & `GDC_MASK_SINK;
                end
                `GDC_ADDR_SENSE: begin
                    // Gain updates are accepted regardless of switching activity.
                    sense_amp_control_reg <= wdata_i & `GDC_MASK_SENSE; // RULE19
                end
                default: begin
                    direct_gate_command_reg <= direct_gate_command_reg;
                end
            endcase
        end
    end

    // Read port: one cycle latency, unmapped addresses read zero.
    always @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o  <= 16'h0000;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_en_i;
            case (addr_i)
                `GDC_ADDR_DIRECT: rdata_o <= direct_gate_command_reg;
                `GDC_ADDR_FORCE:  rdata_o <= phase_force_low_enables_reg;
                `GDC_ADDR_SOURCE: rdata_o <= source_current_codes_reg;
                `GDC_ADDR_SINK:   rdata_o <= sink_current_and_ratio_reg;
                `GDC_ADDR_SENSE:  rdata_o <= sense_amp_control_reg;
                default:          rdata_o <= 16'h0000;
            endcase
        end
    end

    // Gate outputs. Normal control comes from normal_gate_i in order
    // {ha, la, hb, lb, hc, lc}; register mode overrides only the B and C low gates.
    reg  [5:0] gate_next;

    always @* begin
        gate_next = normal_gate_i;
        if (reg_mode) begin
            gate_next[2] = cmd_low_gate_b; // RULE1
            gate_next[0] = cmd_low_gate_c; // RULE2
        end
        if (master_driver_enable_i && !phase_a_force_n) begin
            gate_next[5:4] = 2'h0; // RULE3
        end
        if (master_driver_enable_i && !phase_b_force_n) begin
            gate_next[3:2] = 2'h0; // RULE4
        end
        if (master_driver_enable_i && !phase_c_force_n) begin
            gate_next[1:0] = 2'h0; // RULE5
        end
    end

    // Source current derivation. Scaling multiplies the sink code by the ratio;
    // the analog side sees the code and the active ratio field.
    function [5:0] scale_code;
        input [5:0] code;
        input [1:0] ratio;
        reg   [7:0] prod;
        begin
            prod = {2'h0, code};
            case (ratio)
                2'h0:    prod = {2'h0, code};
                2'h1:    prod = (({2'h0, code} << 1) + {2'h0, code}) >> 2;
                2'h2:    prod = {2'h0, code} >> 1;
                default: prod = {2'h0, code} >> 2;
            endcase
            scale_code = prod[5:0];
        end
    endfunction

    wire hs_sink_high = (hs_sink_code >= `GDC_SINK_HIGH_MIN);
    wire ls_sink_high = (ls_sink_code >= `GDC_SINK_HIGH_MIN);

    // Low-side ratio is qualified by the low-side sink code; the alternative
    // reading that uses the high-side code looked like an editing slip.
    wire hs_ratio_on = !source_config_select_i && !hs_sink_high; // RULE11 RULE12
    wire ls_ratio_on = !source_config_select_i && !ls_sink_high; // RULE13

    reg  [5:0] hs_src_next;
    reg  [5:0] ls_src_next;

    always @* begin
        if (source_config_select_i) begin
            hs_src_next = hs_source_code; // RULE8
            ls_src_next = ls_source_code; // RULE9
        end else begin
            hs_src_next = hs_sink_high ? hs_sink_code : scale_code(hs_sink_code, hs_ratio); // RULE10 RULE20
            ls_src_next = ls_sink_high ? ls_sink_code : scale_code(ls_sink_code, ls_ratio); // RULE13 RULE20
        end
    end

    reg  [5:0] gain_next;

    always @* begin
        case (gain_code_a) // RULE17
            4'h0:    gain_next = 6'h05;
            4'h1:    gain_next = 6'h0A;
            4'h2:    gain_next = 6'h0C;
            4'h3:    gain_next = 6'h10;
            4'h4:    gain_next = 6'h14;
            4'h5:    gain_next = 6'h17;
            4'h6:    gain_next = 6'h19;
            4'h7:    gain_next = 6'h1E;
            default: gain_next = 6'h28; // RULE18
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            {high_gate_out_a_o, low_gate_out_a_o} <= 2'h0;
            {high_gate_out_b_o, low_gate_out_b_o} <= 2'h0;
            {high_gate_out_c_o, low_gate_out_c_o} <= 2'h0;
            hs_source_current_o      <= 6'h00;
            ls_source_current_o      <= 6'h00;
            hs_strength_multiplier_o <= 2'h0;
            ls_strength_multiplier_o <= 2'h0;
            hs_ratio_active_o        <= 1'b0;
            ls_ratio_active_o        <= 1'b0;
            hs_sink_current_o        <= 6'h00;
            ls_sink_current_o        <= 6'h00;
            sense_ref_divisor_o      <= 4'h2;
            amp_gain_phase_a_o       <= 6'h05;
        end else begin
            {high_gate_out_a_o, low_gate_out_a_o} <= gate_next[5:4];
            {high_gate_out_b_o, low_gate_out_b_o} <= gate_next[3:2];
            {high_gate_out_c_o, low_gate_out_c_o} <= gate_next[1:0];
            hs_source_current_o      <= hs_src_next;
            ls_source_current_o      <= ls_src_next;
            hs_strength_multiplier_o <= hs_ratio_on ? hs_ratio : 2'h0; // RULE12
            ls_strength_multiplier_o <= ls_ratio_on ? ls_ratio : 2'h0;
            hs_ratio_active_o        <= hs_ratio_on;
            ls_ratio_active_o        <= ls_ratio_on;
            hs_sink_current_o        <= hs_sink_code; // RULE14
            ls_sink_current_o        <= ls_sink_code; // RULE15
            sense_ref_divisor_o      <= sense_ref_divide ? 4'h8 : 4'h2; // RULE16
            amp_gain_phase_a_o       <= gain_next; // RULE19
        end
    end

endmodule

/* verification/gdc_host_model.sv */
`timescale 1ns/100ps
// Configuration host: launches each access off the falling edge, one strobe cycle each.
module gdc_host_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic             wr_en_o,
    output logic             rd_en_o,
    output logic [5:0]       addr_o,
    output logic [15:0]      wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 6'h00;
        wdata_o = 16'h0000;
    end
    // Released address and data are inverted so a stale value can never pass for a live one.
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_en_o = 1'b1;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task rd(input logic [5:0] a, output logic [15:0] d, output logic v);
        @(negedge clk_i);
        addr_o = a;
        rd_en_o = 1'b1;
        @(negedge clk_i);
        rd_en_o = 1'b0;
        d = rdata_i;
        v = rvalid_i;
        addr_o = ~a;
    endtask
endmodule

/* verification/gdc_regs_chk.sv */
`timescale 1ns/100ps
`include "gdc_map.vh"
module gdc_regs_chk (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        wr_en_i,
    input wire logic        rd_en_i,
    input wire logic [5:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] rdata_o,
    input wire logic [2:0]  pwm_mode_i,
    input wire logic        master_driver_enable_i,
    input wire logic        source_config_select_i,
    input wire logic [5:0]  normal_gate_i,
    input wire logic        high_gate_out_a_o,
    input wire logic        low_gate_out_a_o,
    input wire logic        low_gate_out_b_o,
    input wire logic [5:0]  hs_source_current_o,
    input wire logic        hs_ratio_active_o,
    input wire logic [3:0]  sense_ref_divisor_o,
    input wire logic [5:0]  amp_gain_phase_a_o
);
    // Shadow copies of the registers, rebuilt from the write strobes alone.
    logic [15:0] dir_reg, frc_reg, src_reg, snk_reg, sen_reg;
    wire  [7:0]  hs_75 = ({2'h0, snk_reg[13:8]} * 8'h03) >> 2;
    always @(posedge clk_i) begin
        if (srst_i) begin
            dir_reg <= `GDC_RST_DIRECT;
            frc_reg <= `GDC_RST_FORCE;
            src_reg <= `GDC_RST_SOURCE;
            snk_reg <= `GDC_RST_SINK;
            sen_reg <= `GDC_RST_SENSE;
        end else if (wr_en_i) begin
            case (addr_i)
                `GDC_ADDR_DIRECT: dir_reg <= wdata_i & `GDC_MASK_DIRECT;
                `GDC_ADDR_FORCE:  frc_reg <= wdata_i & `GDC_MASK_FORCE;
                `GDC_ADDR_SOURCE: src_reg <= wdata_i & `GDC_MASK_SOURCE;
                `GDC_ADDR_SINK:   snk_reg <= wdata_i & `GDC_MASK_SINK;
                `GDC_ADDR_SENSE:  sen_reg <= wdata_i & `GDC_MASK_SENSE;
                default: ;
            endcase
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_low_b; (pwm_mode_i == `GDC_PWM_MODE_REG && master_driver_enable_i && frc_reg[1])
        |=> low_gate_out_b_o == $past(dir_reg[1]); endproperty
    a_low_b: assert property (p_low_b) else $error("phase b low gate off command");
    property p_force_a; (master_driver_enable_i && !frc_reg[2])
        |=> !high_gate_out_a_o && !low_gate_out_a_o; endproperty
    a_force_a: assert property (p_force_a) else $error("phase a not pulled low");
    property p_norm_a; (master_driver_enable_i && frc_reg[2] && pwm_mode_i != `GDC_PWM_MODE_REG)
        |=> {high_gate_out_a_o, low_gate_out_a_o} == $past(normal_gate_i[5:4]); endproperty
    a_norm_a: assert property (p_norm_a) else $error("phase a not following pwm");
    property p_div; 1'b1 |=> sense_ref_divisor_o == ($past(sen_reg[15]) ? 4'h8 : 4'h2); endproperty
    a_div: assert property (p_div) else $error("reference divisor wrong");
    property p_gain_top; (sen_reg[11:8] > 4'h8) |=> amp_gain_phase_a_o == 6'h28; endproperty
    a_gain_top: assert property (p_gain_top) else $error("high gain code not 40");
    property p_sel_src; source_config_select_i
        |=> hs_source_current_o == $past(src_reg[13:8]) && !hs_ratio_active_o; endproperty
    a_sel_src: assert property (p_sel_src) else $error("source code not used");
    property p_sink_src; (!source_config_select_i && snk_reg[13:8] >= `GDC_SINK_HIGH_MIN)
        |=> hs_source_current_o == $past(snk_reg[13:8]) && !hs_ratio_active_o; endproperty
    a_sink_src: assert property (p_sink_src) else $error("strong sink not copied");
    property p_r75; (!source_config_select_i && snk_reg[15:14] == 2'h1
        && snk_reg[13:8] < `GDC_SINK_HIGH_MIN) |=> hs_source_current_o == $past(hs_75[5:0])
        && hs_ratio_active_o; endproperty
    a_r75: assert property (p_r75) else $error("three quarter ratio wrong");
    property p_rsvd; (rd_en_i && addr_i == `GDC_ADDR_FORCE) |=> rdata_o[15:3] == 13'h0000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
endmodule
bind gdc_config_regs gdc_regs_chk gdc_regs_chk_inst (.*);

/* verification/gate_drive_config_regs_bench.sv */
`timescale 1ns/100ps
`include "gdc_map.vh"
module gate_drive_config_regs_bench;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [2:0]  pwm_mode_i = 3'h0;
    logic        master_driver_enable_i = 1'b1;
    logic        source_config_select_i = 1'b0;
    logic [5:0]  normal_gate_i = 6'h00;
    wire         wr_en_i, rd_en_i, rvalid_o, hs_ratio_active_o, ls_ratio_active_o;
    wire         high_gate_out_a_o, low_gate_out_a_o, high_gate_out_b_o, low_gate_out_b_o;
    wire         high_gate_out_c_o, low_gate_out_c_o;
    wire  [5:0]  addr_i, hs_source_current_o, ls_source_current_o, hs_sink_current_o;
    wire  [5:0]  ls_sink_current_o, amp_gain_phase_a_o;
    wire  [1:0]  hs_strength_multiplier_o, ls_strength_multiplier_o;
    wire  [15:0] wdata_i, rdata_o;
    wire  [3:0]  sense_ref_divisor_o;
    logic [15:0] rd_v;
    logic        ok;
    integer      error_cnt = 0;
    integer      check_count = 0;
    // Row: sink register word, high and low source codes, high and low ratio-active flags.
    logic [29:0] rows [4] = '{{16'h1091, 6'h10, 6'h08, 2'h3}, {16'h60E3, 6'h18, 6'h08, 2'h3},
                              {16'hA46C, 6'h24, 6'h2C, 2'h0}, {16'hE33F, 6'h08, 6'h3F, 2'h2}};
    logic [5:0]  gains [16] = '{6'h05, 6'h0A, 6'h0C, 6'h10, 6'h14, 6'h17, 6'h19, 6'h1E, 6'h28,
                               6'h28, 6'h28, 6'h28, 6'h28, 6'h28, 6'h28, 6'h28};
    always #5 clk_i = ~clk_i;
    gdc_config_regs gdc_config_regs_inst (.*);
    gdc_host_model gdc_host_model_inst (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
        .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task rdchk(input logic [5:0] a, input logic [15:0] e);
        gdc_host_model_inst.rd(a, rd_v, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(rd_v, e);
    endtask
    // Writes land one edge before the outputs move, so wait one more cycle.
    task wr(input logic [5:0] a, input logic [15:0] d);
        gdc_host_model_inst.wr(a, d);
        @(negedge clk_i);
    endtask
    task close_out;
        if (error_cnt == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #50000;
        error_cnt++;
        close_out;
    end
    initial begin
        repeat (16) @(negedge clk_i);
        srst_i = 1'b0;
        chk({6'h00, sense_ref_divisor_o, amp_gain_phase_a_o}, 16'h0085);
        rdchk(`GDC_ADDR_FORCE, 16'h0007);
        rdchk(`GDC_ADDR_SINK, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(`GDC_ADDR_SINK, rows[i][29:14]);
            chk({hs_source_current_o, ls_source_current_o}, {4'h0, rows[i][13:2]});
            chk({14'h0000, hs_ratio_active_o, ls_ratio_active_o}, {14'h0000, rows[i][1:0]});
            chk({12'h000, hs_strength_multiplier_o, ls_strength_multiplier_o},
                {12'h000, rows[i][1] ? rows[i][29:28] : 2'h0,
                 rows[i][0] ? rows[i][21:20] : 2'h0});
            chk({hs_sink_current_o, ls_sink_current_o}, {4'h0, rows[i][27:22], rows[i][19:14]});
        end
        for (int i = 0; i < 16; i++) begin
            normal_gate_i = ~normal_gate_i;
            wr(`GDC_ADDR_SENSE, {i[0], 3'h7, i[3:0], 8'hFF});
            chk({10'h000, amp_gain_phase_a_o}, {10'h000, gains[i]});
            chk({12'h000, sense_ref_divisor_o}, i[0] ? 16'h0008 : 16'h0002);
            rdchk(`GDC_ADDR_SENSE, {i[0], 3'h0, i[3:0], 8'h00});
        end
        normal_gate_i = 6'h3F;
        wr(`GDC_ADDR_FORCE, 16'hFFF8);
        chk({high_gate_out_a_o, low_gate_out_a_o, high_gate_out_b_o, low_gate_out_b_o,
            high_gate_out_c_o, low_gate_out_c_o, master_driver_enable_i}, 16'h0001);
        normal_gate_i = 6'h2A;
        wr(`GDC_ADDR_FORCE, 16'h0005);
        chk({high_gate_out_a_o, low_gate_out_a_o, high_gate_out_b_o, low_gate_out_b_o,
            high_gate_out_c_o, low_gate_out_c_o}, 16'h0022);
        wr(`GDC_ADDR_FORCE, 16'h0007);
        pwm_mode_i = `GDC_PWM_MODE_REG;
        wr(`GDC_ADDR_DIRECT, 16'hFFFE);
        chk({low_gate_out_b_o, low_gate_out_c_o}, 16'h0002);
        wr(`GDC_ADDR_DIRECT, 16'h0001);
        chk({low_gate_out_b_o, low_gate_out_c_o}, 16'h0001);
        rdchk(`GDC_ADDR_DIRECT, 16'h0001);
        source_config_select_i = 1'b1;
        wr(`GDC_ADDR_SOURCE, 16'hD2A5);
        chk({hs_source_current_o, ls_source_current_o}, 16'h04A5);
        chk({hs_ratio_active_o, ls_ratio_active_o}, 16'h0000);
        chk({hs_strength_multiplier_o, ls_strength_multiplier_o}, 16'h0000);
        rdchk(`GDC_ADDR_SOURCE, 16'h1225);
        wr(6'h27, 16'hFFFF);
        rdchk(6'h27, 16'h0000);
        srst_i = 1'b1;
        @(negedge clk_i);
        srst_i = 1'b0;
        rdchk(`GDC_ADDR_FORCE, 16'h0007);
        rdchk(`GDC_ADDR_SOURCE, 16'h0000);
        close_out;
    end
endmodule
